// file: src/uhb_host_bus_ctl.sv
// host bus control: supply gating, attach/detach, bus reset, frames, descriptor fetch
//
// The implementer's own choices: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
`include "uhb_defines.svh"
module uhb_host_bus_ctl
    import uhb_pkg::*;
#(
    parameter int RESET_CYCLES = `UHB_RESET_TIME_US * `UHB_CLK_MHZ,
    parameter int FRAME_CYCLES = `UHB_FRAME_TIME_US * `UHB_CLK_MHZ
)
(
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    input  wire logic [7:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    output logic [31:0]      o_avs_readdata,
    output logic             o_avs_waitrequest,
    output logic [31:0]      o_avm_address,
    output logic             o_avm_read,
    input  wire logic [31:0] i_avm_readdata,
    input  wire logic        i_avm_waitrequest,
    input  wire uhb_line_s   i_line,
    output uhb_line_s        o_line,
    output logic             o_line_oe,
    output logic             o_sof,
    output logic             o_irq
);
    ////////////////////////////////////////////////////////////////////////////
    logic        ph_reg, ph_next, wait_reg, wait_next;
    logic [31:0] rdata_reg, rdata_next;
    logic        en_reg, en_next, sup_reg, sup_next, fmg_en_reg, fmg_en_next;
    uhb_bus_e    st_reg, st_next;
    logic [19:0] cnt_reg, cnt_next;
    logic [16:0] fcnt_reg, fcnt_next;
    logic [10:0] frnum_reg, frnum_next;
    logic [7:0]  bint_reg, bint_next, sofc_reg, sofc_next;
    logic [7:0]  pflag_reg, pflag_next, pien_reg, pien_next, pfrz_reg, pfrz_next;
    logic [15:0] iflag_reg, iflag_next, ien_reg, ien_next;
    logic        conn_reg, conn_next;
    logic [1:0]  rate_reg, rate_next;
    logic [31:0] base_reg, base_next, fdata_reg, fdata_next, maddr_reg, maddr_next;
    logic        mrd_reg, mrd_next, sof_reg, sof_next, irq_reg, irq_next;
    uhb_line_s   lout_reg, lout_next;
    logic        loe_reg, loe_next;
    logic        req, wr_take, run, start_rst, rst_done, attach, detach;
    logic [15:0] iset;
    logic [7:0]  pipe_cfg_rdata;
    uhb_cfg_wr_s cfg_wr;

    function automatic logic [31:0] desc_addr(input logic [31:0] base, input logic [2:0] pipe);
        desc_addr = base + `UHB_DESC_STRIDE * {29'h0, pipe};
    endfunction

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // every access answers in its third cycle so pipe config read data is ready
    assign req     = i_avs_read | i_avs_write;
    assign wr_take = i_avs_write & ~wait_reg;
    assign run     = en_reg & sup_reg;
    assign start_rst = wr_take && hit(i_avs_address, `UHB_OFS_CTRL) &&
                       i_avs_writedata[`UHB_CTRL_BRST] && run && st_reg == UHB_ST_IDLE;
    assign rst_done  = st_reg == UHB_ST_RESET && cnt_reg == 20'(RESET_CYCLES - 1);
    // attach on either line high
    // own reset drive lingers one cycle past the state change; no false detach from it
    assign attach = run && st_reg == UHB_ST_IDLE && !loe_reg && !conn_reg && (|i_line);
    assign detach = run && st_reg == UHB_ST_IDLE && !loe_reg && conn_reg && !(|i_line);

    assign cfg_wr.we    = wr_take && i_avs_address[7:5] == 3'h2;
    assign cfg_wr.addr  = i_avs_address[4:2];
    assign cfg_wr.wdata = i_avs_writedata[7:0];

    uhb_pipe_cfg_mem u_pipe_cfg (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_clear (start_rst),
        .i_wr    (cfg_wr),
        .i_raddr (i_avs_address[4:2]),
        .o_rdata (pipe_cfg_rdata)
    );

    ////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        ph_next    = ph_reg;
        wait_next  = 1'b1;
        rdata_next = rdata_reg;
        if (req && wait_reg)
        begin
            ph_next   = ~ph_reg;
            wait_next = ~ph_reg;
        end
        else if (req)
        begin
            ph_next = 1'b0;
        end
        if (req && wait_reg && ph_reg)
        begin
            unique case (i_avs_address)
                `UHB_OFS_CTRL:      rdata_next = {28'h0, fmg_en_reg, st_reg == UHB_ST_RESET,
                                                  sup_reg, en_reg};
                // line state and link rate readable
                `UHB_OFS_STATUS:    rdata_next = {26'h0, run, conn_reg, rate_reg,
                                                  i_line.dm, i_line.dp};
                `UHB_OFS_IFLAG:     rdata_next = {16'h0, iflag_reg};
                `UHB_OFS_IEN_CLR,
                `UHB_OFS_IEN_SET:   rdata_next = {16'h0, ien_reg};
                `UHB_OFS_DESC_BASE: rdata_next = base_reg;
                `UHB_OFS_FRNUM:     rdata_next = {21'h0, frnum_reg};
                `UHB_OFS_BINT:      rdata_next = {24'h0, bint_reg};
                `UHB_OFS_SOFC:      rdata_next = {24'h0, sofc_reg};
                `UHB_OFS_PFLAG:     rdata_next = {24'h0, pflag_reg};
                `UHB_OFS_PIEN:      rdata_next = {24'h0, pien_reg};
                `UHB_OFS_PFRZ:      rdata_next = {24'h0, pfrz_reg};
                `UHB_OFS_FETCH:     rdata_next = {31'h0, mrd_reg};
                `UHB_OFS_FDATA:     rdata_next = fdata_reg;
                default:            rdata_next = (i_avs_address[7:5] == 3'h2) ?
                                                 {24'h0, pipe_cfg_rdata} : 32'h0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        en_next = en_reg;     sup_next = sup_reg;     fmg_en_next = fmg_en_reg;
        st_next = st_reg;     cnt_next = cnt_reg;     fcnt_next = fcnt_reg;
        frnum_next = frnum_reg; bint_next = bint_reg; sofc_next = sofc_reg;
        pflag_next = pflag_reg; pien_next = pien_reg; pfrz_next = pfrz_reg;
        ien_next = ien_reg;   conn_next = conn_reg;   rate_next = rate_reg;
        base_next = base_reg; fdata_next = fdata_reg; maddr_next = maddr_reg;
        mrd_next = mrd_reg;   sof_next = 1'b0;        iset = 16'h0;
        lout_next = '0;
        loe_next  = st_reg == UHB_ST_RESET;
        if (wr_take)
        begin
            unique case (i_avs_address)
                `UHB_OFS_CTRL:
                begin
                    en_next   = i_avs_writedata[`UHB_CTRL_EN];
                    sup_next  = i_avs_writedata[`UHB_CTRL_SUPPLY];
                    fmg_en_next = i_avs_writedata[`UHB_CTRL_FMG_EN];
                end
                `UHB_OFS_IEN_CLR:   ien_next = ien_reg & ~i_avs_writedata[15:0];
                `UHB_OFS_IEN_SET:   ien_next = ien_reg | (i_avs_writedata[15:0] & `UHB_IRQ_MASK);
                `UHB_OFS_DESC_BASE: base_next = i_avs_writedata;
                `UHB_OFS_BINT:      bint_next = i_avs_writedata[7:0];
                `UHB_OFS_SOFC:      sofc_next = i_avs_writedata[7:0];
                `UHB_OFS_PFLAG:     pflag_next = pflag_reg & ~i_avs_writedata[7:0];
                `UHB_OFS_PIEN:      pien_next = i_avs_writedata[7:0];
                `UHB_OFS_PFRZ:      pfrz_next = i_avs_writedata[7:0];
                `UHB_OFS_FETCH:
                begin
                    if (!mrd_reg && run)
                    begin
                        mrd_next   = 1'b1;
                        maddr_next = desc_addr(base_reg, i_avs_writedata[2:0]);
                    end
                end
                default:            ;
            endcase
        end
        if (mrd_reg && !i_avm_waitrequest)
        begin
            mrd_next   = 1'b0;
            fdata_next = i_avm_readdata;
        end
        if (attach)
        begin
            conn_next = 1'b1;
            rate_next = i_line.dm ? `UHB_RATE_LOW : `UHB_RATE_FULL;
            iset[`UHB_IRQ_ATTACH] = 1'b1;
        end
        if (detach)
        begin
            conn_next = 1'b0;
            iset[`UHB_IRQ_DETACH] = 1'b1;
        end
        // device-driven DM high, DP low while suspended is taken as upstream resume, whatever rate_reg holds
        if (run && conn_reg && !fmg_en_reg && st_reg == UHB_ST_IDLE && i_line.dm && !i_line.dp)
        begin
            iset[`UHB_IRQ_UP_RESUME] = 1'b1;
        end
        if (run && fmg_en_reg && conn_reg && st_reg == UHB_ST_IDLE)
        begin
            fcnt_next = fcnt_reg + 17'h1;
            if (fcnt_reg == 17'(FRAME_CYCLES - 1))
            begin
                fcnt_next = 17'h0;
                frnum_next = frnum_reg + 11'h1;
                sof_next  = 1'b1;
                iset[`UHB_IRQ_FRAME] = 1'b1;
            end
        end
        unique case (st_reg)
            UHB_ST_IDLE:
            begin
                if (start_rst)
                begin
                    st_next  = UHB_ST_RESET;
                    cnt_next = 20'h0;
                    if (!fmg_en_reg)
                    begin
                        iset[`UHB_IRQ_WAKE] = 1'b1;
                    end
                    fmg_en_next = 1'b1;
                    frnum_next = 11'h0; fcnt_next = 17'h0;
                    bint_next = 8'h0;   sofc_next = 8'h0;
                    pflag_next = 8'h0;  pien_next = 8'h0;  pfrz_next = 8'h0;
                end
            end
            UHB_ST_RESET:
            begin
                cnt_next = cnt_reg + 20'h1;
                if (!run)
                begin
                    st_next = UHB_ST_IDLE;
                end
                else if (rst_done)
                begin
                    // reset sent flag; pipes stay cleared
                    st_next = UHB_ST_IDLE;
                    iset[`UHB_IRQ_RST] = 1'b1;
                end
            end
        endcase
        // halt zeroes the frame timer; frame enable keeps its value unless CTRL is written
        if (!run)
        begin
            fmg_en_next = wr_take && hit(i_avs_address, `UHB_OFS_CTRL) ? fmg_en_next : fmg_en_reg;
            fcnt_next = 17'h0;
        end
        // hardware set wins over a software clear in the same cycle
        iflag_next = (wr_take && hit(i_avs_address, `UHB_OFS_IFLAG)) ?
                     (iflag_reg & ~i_avs_writedata[15:0]) : iflag_reg;
        iflag_next = iflag_next | iset;
        irq_next = |(iflag_reg & ien_reg);
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            ph_reg <= 1'b0;   wait_reg <= 1'b1;  rdata_reg <= 32'h0;
            en_reg <= 1'b0;   sup_reg <= 1'b0;   fmg_en_reg <= 1'b0;
            st_reg <= UHB_ST_IDLE;               cnt_reg <= 20'h0;
            fcnt_reg <= 17'h0; frnum_reg <= 11'h0; bint_reg <= 8'h0;
            sofc_reg <= 8'h0; pflag_reg <= 8'h0; pien_reg <= 8'h0;
            pfrz_reg <= 8'h0; iflag_reg <= 16'h0; ien_reg <= 16'h0;
            conn_reg <= 1'b0; rate_reg <= 2'h0;  base_reg <= 32'h0;
            fdata_reg <= 32'h0; maddr_reg <= 32'h0; mrd_reg <= 1'b0;
            sof_reg <= 1'b0;  irq_reg <= 1'b0;   lout_reg <= '0;
            loe_reg <= 1'b0;
        end
        else
        begin
            ph_reg <= ph_next;   wait_reg <= wait_next; rdata_reg <= rdata_next;
            en_reg <= en_next;   sup_reg <= sup_next;   fmg_en_reg <= fmg_en_next;
            st_reg <= st_next;   cnt_reg <= cnt_next;
            fcnt_reg <= fcnt_next; frnum_reg <= frnum_next; bint_reg <= bint_next;
            sofc_reg <= sofc_next; pflag_reg <= pflag_next; pien_reg <= pien_next;
            pfrz_reg <= pfrz_next; iflag_reg <= iflag_next; ien_reg <= ien_next;
            conn_reg <= conn_next; rate_reg <= rate_next; base_reg <= base_next;
            fdata_reg <= fdata_next; maddr_reg <= maddr_next; mrd_reg <= mrd_next;
            sof_reg <= sof_next; irq_reg <= irq_next;   lout_reg <= lout_next;
            loe_reg <= loe_next;
        end
    end

    assign o_avs_readdata    = rdata_reg;
    assign o_avs_waitrequest = wait_reg;
    assign o_avm_address     = maddr_reg;
    assign o_avm_read        = mrd_reg;
    assign o_line            = lout_reg;
    assign o_line_oe         = loe_reg;
    assign o_sof             = sof_reg;
    assign o_irq             = irq_reg;

    ////////////////////////////////////////////////////////////////////////////
    a_halt_blocks_reset: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !run |=> st_reg == UHB_ST_IDLE) else $error("bus reset runs while halted");
    a_attach_sets_flag: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        attach |=> iflag_reg[`UHB_IRQ_ATTACH] && conn_reg) else $error("attach lost");
    a_detach_sets_flag: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        detach |=> iflag_reg[`UHB_IRQ_DETACH] && !conn_reg) else $error("detach lost");
    a_reset_drives_se0: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        start_rst |=> ##1 o_line_oe && o_line == '0) else $error("no reset signalling");
    a_reset_sent_flag: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        rst_done && run |=> iflag_reg[`UHB_IRQ_RST] && st_reg == UHB_ST_IDLE)
        else $error("reset sent flag missing");
    a_resume_wake_fmg: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        start_rst && !fmg_en_reg |=> iflag_reg[`UHB_IRQ_WAKE] && fmg_en_reg)
        else $error("resume from suspend missing");
    a_reset_clears_state: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        start_rst |=> frnum_reg == 11'h0 && pien_reg == 8'h0 && pfrz_reg == 8'h0 &&
        bint_reg == 8'h0 && sofc_reg == 8'h0) else $error("reset left pipe state");
    a_enclr_bit3: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        wr_take && hit(i_avs_address, `UHB_OFS_IEN_CLR) && i_avs_writedata[3]
        |=> !ien_reg[3]) else $error("enable clear ignored");
    a_enclr_zero_keeps: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        wr_take && hit(i_avs_address, `UHB_OFS_IEN_CLR) && !i_avs_writedata[6]
        |=> ien_reg[6] == $past(ien_reg[6])) else $error("zero write changed enable");
    a_irq_follows: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (|(iflag_reg & ien_reg)) |=> o_irq) else $error("irq not raised");
    a_bus_answer: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        req && wait_reg && !ph_reg |=> ##1 !o_avs_waitrequest) else $error("slow answer");
endmodule // uhb_host_bus_ctl

// file: src/uhb_defines.svh
// offsets, field positions, masks and timing for the host bus control block
`ifndef UHB_DEFINES_SVH
`define UHB_DEFINES_SVH
`define UHB_CLK_MHZ        100
`define UHB_RESET_TIME_US  10000
`define UHB_FRAME_TIME_US  1000
`define UHB_OFS_CTRL       8'h00
`define UHB_OFS_STATUS     8'h04
`define UHB_OFS_IFLAG      8'h08
`define UHB_OFS_IEN_CLR    8'h0c
`define UHB_OFS_IEN_SET    8'h10
`define UHB_OFS_DESC_BASE  8'h14
`define UHB_OFS_FRNUM      8'h18
`define UHB_OFS_BINT       8'h1c
`define UHB_OFS_SOFC       8'h20
`define UHB_OFS_PFLAG      8'h24
`define UHB_OFS_PIEN       8'h28
`define UHB_OFS_PFRZ       8'h2c
`define UHB_OFS_FETCH      8'h30
`define UHB_OFS_FDATA      8'h34
`define UHB_OFS_PIPE_CFG   8'h40
`define UHB_CTRL_EN        0
`define UHB_CTRL_SUPPLY    1
`define UHB_CTRL_BRST      2
`define UHB_CTRL_FMG_EN    3
`define UHB_IRQ_FRAME      2
`define UHB_IRQ_RST        3
`define UHB_IRQ_WAKE       4
`define UHB_IRQ_DN_RESUME  5
`define UHB_IRQ_UP_RESUME  6
`define UHB_IRQ_ATTACH     8
`define UHB_IRQ_DETACH     9
`define UHB_IRQ_MASK       16'h037c
`define UHB_NPIPE          8
`define UHB_DESC_STRIDE    32'h0000_0020
`define UHB_RATE_LOW       2'h1
`define UHB_RATE_FULL      2'h2
`endif

// file: src/uhb_pkg.sv
// types shared by the host bus control block
package uhb_pkg;
    typedef enum logic [0:0] {
        UHB_ST_IDLE  = 1'b0,
        UHB_ST_RESET = 1'b1
    } uhb_bus_e;

    typedef struct packed {
        logic dm;
        logic dp;
    } uhb_line_s;

    typedef struct packed {
        logic        we;
        logic [2:0]  addr;
        logic [7:0]  wdata;
    } uhb_cfg_wr_s;
endpackage

// file: src/uhb_pipe_cfg_mem.sv
// pipe configuration store, registered read, clear-all port
`timescale 1ns/1ps
`include "uhb_defines.svh"
module uhb_pipe_cfg_mem
    import uhb_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_clear,
    input  wire uhb_cfg_wr_s i_wr,
    input  wire logic [2:0]  i_raddr,
    output logic [7:0]       o_rdata
);
    logic [7:0] mem_reg  [`UHB_NPIPE];
    logic [7:0] mem_next [`UHB_NPIPE];
    logic [7:0] rdata_next;

    always_comb
    begin
        for (int i = 0; i < `UHB_NPIPE; i++)
        begin
            mem_next[i] = i_clear ? 8'h00 : mem_reg[i];
        end
        if (i_wr.we && !i_clear)
        begin
            mem_next[i_wr.addr] = i_wr.wdata;
        end
        rdata_next = mem_reg[i_raddr];
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            for (int i = 0; i < `UHB_NPIPE; i++)
            begin
                mem_reg[i] <= 8'h00;
            end
            o_rdata <= 8'h00;
        end
        else
        begin
            mem_reg <= mem_next;
            o_rdata <= rdata_next;
        end
    end
endmodule // uhb_pipe_cfg_mem

// file: dv/uhb_dev_model.sv
// usb peripheral model that pulls up one data line of the DP/DM pair
`timescale 1ns/1ps
module uhb_dev_model
    import uhb_pkg::*;
(
    input  wire logic      i_attach,
    input  wire logic      i_low_speed,
    input  wire uhb_line_s i_host_line,
    input  wire logic      i_host_oe,
    output uhb_line_s      o_wire
);
    ////////////////////////////////////////////////////////////////////////////////
    // host drive beats the weak pull-up; detached, the host pull-downs leave both low
    always_comb
    begin
        if (i_host_oe)
            o_wire = i_host_line;
        else if (i_attach)
            o_wire = i_low_speed ? 2'h2 : 2'h1;
        else
            o_wire = 2'h0;
    end
endmodule // uhb_dev_model

// file: dv/tb_top.sv
// self-checking bench for the host bus control block
`timescale 1ns/1ps
module tb_top;
    import uhb_pkg::*;
    logic        i_clk = 1'b0;
    logic        i_rst_n = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic        attach = 1'b0;
    logic        low = 1'b0;
    logic        mwait = 1'b1;
    logic [31:0] wdat = 32'h0;
    logic [31:0] mdat = 32'h0;
    logic [31:0] rdat, maddr, exp_addr, base, cfg_val;
    logic        wreq, mrd, oe, sof, irq;
    uhb_line_s   hline, wire_l;
    logic [31:0] exp_q[$], msk_q[$];
    int          fails = 0, check_count = 0, seed = 32'h4562, k;

    always #5 i_clk = ~i_clk;

    uhb_host_bus_ctl #(.RESET_CYCLES(20), .FRAME_CYCLES(50)) u_dut (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_avs_address(adr), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata(wdat), .o_avs_readdata(rdat),
        .o_avs_waitrequest(wreq), .o_avm_address(maddr), .o_avm_read(mrd),
        .i_avm_readdata(mdat), .i_avm_waitrequest(mwait), .i_line(wire_l),
        .o_line(hline), .o_line_oe(oe), .o_sof(sof), .o_irq(irq));

    uhb_dev_model u_dev (.i_attach(attach), .i_low_speed(low), .i_host_line(hline),
        .i_host_oe(oe), .o_wire(wire_l));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            fails++;
            $display("FAIL %0t got %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict;
        if (fails == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // for a read, d is the expected value under mask m
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] m);
        @(posedge i_clk);
        adr <= a;
        wdat <= w ? d : 32'h0;
        wr <= w;
        rd <= !w;
        if (!w)
        begin
            exp_q.push_back(d);
            msk_q.push_back(m);
        end
        do @(posedge i_clk); while (wreq !== 1'b0);
        wr <= 1'b0;
        rd <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // result watcher; memory answers a fetch at random, one chance in four per cycle, never in its first cycle
    always @(posedge i_clk)
    begin
        if (wreq === 1'b0 && rd === 1'b1 && exp_q.size() > 0)
            chk(rdat & msk_q.pop_front(), exp_q.pop_front());
        if (mrd === 1'b1 && mwait === 1'b0)
            chk(maddr, exp_addr);
        mwait <= !(mrd === 1'b1 && ($random(seed) & 3) == 0);
    end

    initial
    begin
        repeat (5000) @(posedge i_clk);
        fails++;
        print_verdict;
    end

    initial
    begin
        repeat (8) @(posedge i_clk);
        i_rst_n <= 1'b1;
        bus(0, 8'h00, 32'h0, 32'hf);
        bus(1, 8'h00, 32'h1, 0);
        attach <= 1'b1;
        repeat (4) @(posedge i_clk);
        bus(0, 8'h08, 32'h0, 32'h100);
        bus(0, 8'h04, 32'h1, 32'h23);
        bus(1, 8'h00, 32'h3, 0);
        bus(0, 8'h08, 32'h100, 32'h100);
        bus(0, 8'h04, 32'h39, 32'h3f);
        bus(1, 8'h10, 32'h37c, 0);
        bus(0, 8'h0c, 32'h37c, 32'hffff);
        chk(irq, 32'h1);
        for (k = 2; k < 7; k++)
        begin
            bus(1, 8'h0c, 32'h0, 0);
            bus(1, 8'h0c, 32'h1 << k, 0);
            bus(0, 8'h0c, 32'h37c & ~((32'h1 << (k + 1)) - 1), 32'hffff);
        end
        bus(1, 8'h0c, 32'h300, 0);
        bus(0, 8'h0c, 32'h0, 32'hffff);
        chk(irq, 32'h0);
        cfg_val = ($random(seed) & 32'hff) | 32'h1;
        bus(1, 8'h40, cfg_val, 0);
        bus(0, 8'h40, cfg_val, 32'hff);
        bus(1, 8'h1c, 32'h33, 0);
        bus(1, 8'h28, 32'hff, 0);
        bus(1, 8'h00, 32'h7, 0);
        while (oe !== 1'b1) @(posedge i_clk);
        chk({30'h0, hline}, 32'h0);
        bus(0, 8'h00, 32'h4, 32'h4);
        while (oe !== 1'b0) @(posedge i_clk);
        repeat (2) @(posedge i_clk);
        // attach flag still up from the first connect; no detach from our own reset drive
        bus(0, 8'h08, 32'h118, 32'h318);
        bus(0, 8'h04, 32'h39, 32'h3f);
        bus(0, 8'h00, 32'h8, 32'hc);
        bus(0, 8'h28, 32'h0, 32'hff);
        bus(0, 8'h40, 32'h0, 32'hff);
        bus(0, 8'h1c, 32'h0, 32'hffffffff);
        k = 0;
        while (sof !== 1'b1 && k < 60)
        begin
            @(posedge i_clk);
            k++;
        end
        chk(sof, 32'h1);
        attach <= 1'b0;
        repeat (3) @(posedge i_clk);
        bus(0, 8'h08, 32'h200, 32'h200);
        bus(1, 8'h08, 32'h3ff, 0);
        bus(0, 8'h08, 32'h0, 32'h318);
        low <= 1'b1;
        attach <= 1'b1;
        repeat (3) @(posedge i_clk);
        bus(0, 8'h04, 32'h16, 32'h1f);
        base = $random(seed) & 32'hffff_ff00;
        k = $random(seed) & 7;
        exp_addr = base + 32 * k;
        mdat <= $random(seed);
        bus(1, 8'h14, base, 0);
        bus(1, 8'h30, k, 0);
        while (mrd !== 1'b1) @(posedge i_clk);
        while (mrd !== 1'b0) @(posedge i_clk);
        repeat (2) @(posedge i_clk);
        bus(0, 8'h34, mdat, 32'hffffffff);
        print_verdict;
    end
endmodule // tb_top
